// >>> rtl/pdos_pkg.sv
// constants for the power-down order sequencer
// assumes a 125 MHz system clock and byte-wide register access
package pdos_pkg;

  localparam int unsigned NUM_OUTPUTS   = 7;
  localparam int unsigned SLOT_W        = 3;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned ADDR_W        = 8;

  // output index order within every vector
  localparam int unsigned IDX_BUCK_A    = 0;
  localparam int unsigned IDX_BUCK_B    = 1;
  localparam int unsigned IDX_BUCK_C    = 2;
  localparam int unsigned IDX_LDO_A     = 3;
  localparam int unsigned IDX_LDO_B     = 4;
  localparam int unsigned IDX_LDO_C     = 5;
  localparam int unsigned IDX_MEMREF    = 6;

  // register offsets
  localparam logic [7:0] BUCK_A_SHUTDOWN_SLOT_ADDR = 8'h5f;
  localparam logic [7:0] BUCK_B_SHUTDOWN_SLOT_ADDR = 8'h60;
  localparam logic [7:0] BUCK_C_SHUTDOWN_SLOT_ADDR = 8'h61;
  localparam logic [7:0] LDO_A_SHUTDOWN_SLOT_ADDR  = 8'h62;
  localparam logic [7:0] LDO_B_SHUTDOWN_SLOT_ADDR  = 8'h63;
  localparam logic [7:0] LDO_C_SHUTDOWN_SLOT_ADDR  = 8'h64;
  localparam logic [7:0] MEMREF_SHUTDOWN_SLOT_ADDR = 8'h65;

  // field layout and reset values
  localparam int unsigned SLOT_LSB      = 0;
  localparam int unsigned SLOT_MSB      = 2;
  localparam logic [2:0] SLOT_RESET     = 3'h0;
  localparam logic [2:0] SLOT_TOP       = 3'h7;
  localparam logic [2:0] SLOT_BOTTOM    = 3'h0;
  localparam logic [7:0] RDATA_RESET    = 8'h00;
  localparam logic [6:0] ALL_ON         = 7'h7f;
  localparam logic [6:0] ALL_OFF        = 7'h00;

  // pause between two occupied slots
  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned SLOT_GAP_NS   = 2000;
  localparam int unsigned SLOT_GAP_CYC  = (SLOT_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned GAP_CNT_W     = 9;
  localparam logic [8:0] GAP_LOAD       = 9'(SLOT_GAP_CYC - 1);
  localparam logic [8:0] GAP_ZERO       = 9'h000;

  typedef enum logic [1:0] {
    PDOS_IDLE,
    PDOS_STEP,
    PDOS_GAP,
    PDOS_DONE
  } pdos_state_e;

endpackage : pdos_pkg

// >>> rtl/pdos_slot_cell.sv
// one shutdown order field with its byte register
// assumes the fused start-up slot is steady from reset release onward
`timescale 1ns/1ps
`default_nettype none

module pdos_slot_cell
  import pdos_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              rst_n_in,
  // fused start-up slot
  input  wire logic [SLOT_W-1:0] startup_slot_fused_in,
  input  wire logic              load_fused_in,
  // register write
  input  wire logic              wr_en_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  // field value
  output var  logic [SLOT_W-1:0] slot_out
);

  logic [SLOT_W-1:0] slot_reg;

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      slot_reg <= SLOT_RESET;
    else if (load_fused_in)
      slot_reg <= startup_slot_fused_in;
    else if (wr_en_in)
      slot_reg <= wdata_in[SLOT_MSB:SLOT_LSB];
  end

  assign slot_out = slot_reg;

endmodule : pdos_slot_cell

`default_nettype wire

// >>> rtl/pdos_sequencer.sv
// power-down order sequencer: seven order fields and the stepper
// assumes register strobes and the trigger come from logic on sys_clk_in
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - each output has its own three-bit order field in bits 2 to 0 of its register.
// - seven outputs are covered, three bucks, three linear regulators and the memory reference.
// - after reset each order field takes the output's fused start-up slot.
// - once triggered, outputs go off slot by slot from the highest value downward.
// - start-up slots come only from the fused inputs and order-field writes never touch them.
// - when every order field is zero, all outputs go off at once.
module pdos_sequencer
  import pdos_pkg::*;
(
  // clock and reset
  input  wire logic                          sys_clk_in,
  input  wire logic                          rst_n_in,
  // fused start-up slots, one field per output
  input  wire logic [NUM_OUTPUTS*SLOT_W-1:0] startup_slot_fused_in,
  // system state and trigger
  input  wire logic                          system_on_in,
  input  wire logic                          shutdown_trigger_in,
  // register port
  input  wire logic [ADDR_W-1:0]             reg_addr_in,
  input  wire logic [DATA_W-1:0]             reg_wdata_in,
  input  wire logic                          reg_wr_in,
  input  wire logic                          reg_rd_in,
  output var  logic [DATA_W-1:0]             reg_rdata_out,
  // regulator enables and status
  output var  logic [NUM_OUTPUTS-1:0]        output_enable_out,
  output var  logic                          seq_busy_out,
  output var  logic                          seq_done_out
);

  ////////////////////////////////////////////////////////////////////////////
  logic                          load_pending_reg;
  logic [NUM_OUTPUTS-1:0]        hit_vec;
  logic [NUM_OUTPUTS-1:0]        wr_sel;
  logic [NUM_OUTPUTS*SLOT_W-1:0] slot_vec;
  logic                          all_zero;
  logic [SLOT_W-1:0]             rd_slot;
  logic                          rd_hit;
  pdos_state_e                   state_reg;
  logic [SLOT_W-1:0]             cur_slot_reg;
  logic [GAP_CNT_W-1:0]          gap_cnt_reg;
  logic [NUM_OUTPUTS-1:0]        enable_reg;

  // fused values picked up one edge after reset release, not under reset
  // one-shot fused load
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      load_pending_reg <= 1'b1;
    else
      load_pending_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  always_comb
  begin
    wr_sel = '0;
    // a write on the load edge would be lost under the fused copy
    // writes only while on
    if (reg_wr_in && system_on_in && !load_pending_reg)
    begin
      unique case (reg_addr_in)
        BUCK_A_SHUTDOWN_SLOT_ADDR: wr_sel[IDX_BUCK_A] = 1'b1;
        BUCK_B_SHUTDOWN_SLOT_ADDR: wr_sel[IDX_BUCK_B] = 1'b1;
        BUCK_C_SHUTDOWN_SLOT_ADDR: wr_sel[IDX_BUCK_C] = 1'b1;
        LDO_A_SHUTDOWN_SLOT_ADDR:  wr_sel[IDX_LDO_A]  = 1'b1;
        LDO_B_SHUTDOWN_SLOT_ADDR:  wr_sel[IDX_LDO_B]  = 1'b1;
        LDO_C_SHUTDOWN_SLOT_ADDR:  wr_sel[IDX_LDO_C]  = 1'b1;
        MEMREF_SHUTDOWN_SLOT_ADDR: wr_sel[IDX_MEMREF] = 1'b1;
        default:                   wr_sel = '0;
      endcase
    end
  end

  for (genvar g = 0; g < NUM_OUTPUTS; g++)
  begin : g_cell
    pdos_slot_cell u_cell (
      .sys_clk_in            (sys_clk_in),
      .rst_n_in              (rst_n_in),
      .startup_slot_fused_in (startup_slot_fused_in[g*SLOT_W +: SLOT_W]),
      .load_fused_in         (load_pending_reg),
      .wr_en_in              (wr_sel[g]),
      .wdata_in              (reg_wdata_in),
      .slot_out              (slot_vec[g*SLOT_W +: SLOT_W])
    );
    // equal fields hit together, so one slot can drop several rails
    assign hit_vec[g] = (slot_vec[g*SLOT_W +: SLOT_W] == cur_slot_reg);
  end

  assign all_zero = (slot_vec == '0);

  ////////////////////////////////////////////////////////////////////////////
  // read path; unmapped offsets and bits 7 to 3 read zero
  // address taken combinationally at the read edge
  always_comb
  begin
    rd_hit  = 1'b1;
    rd_slot = SLOT_RESET;
    unique case (reg_addr_in)
      BUCK_A_SHUTDOWN_SLOT_ADDR: rd_slot = slot_vec[IDX_BUCK_A*SLOT_W +: SLOT_W];
      BUCK_B_SHUTDOWN_SLOT_ADDR: rd_slot = slot_vec[IDX_BUCK_B*SLOT_W +: SLOT_W];
      BUCK_C_SHUTDOWN_SLOT_ADDR: rd_slot = slot_vec[IDX_BUCK_C*SLOT_W +: SLOT_W];
      LDO_A_SHUTDOWN_SLOT_ADDR:  rd_slot = slot_vec[IDX_LDO_A*SLOT_W +: SLOT_W];
      LDO_B_SHUTDOWN_SLOT_ADDR:  rd_slot = slot_vec[IDX_LDO_B*SLOT_W +: SLOT_W];
      LDO_C_SHUTDOWN_SLOT_ADDR:  rd_slot = slot_vec[IDX_LDO_C*SLOT_W +: SLOT_W];
      MEMREF_SHUTDOWN_SLOT_ADDR: rd_slot = slot_vec[IDX_MEMREF*SLOT_W +: SLOT_W];
      default:                   rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      reg_rdata_out <= RDATA_RESET;
    else if (reg_rd_in)
      reg_rdata_out <= rd_hit ? {{(DATA_W-SLOT_W){1'b0}}, rd_slot} : RDATA_RESET;
  end

  ////////////////////////////////////////////////////////////////////////////
  // stepper
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg    <= PDOS_IDLE;
      cur_slot_reg <= SLOT_TOP;
      gap_cnt_reg  <= GAP_ZERO;
    end
    else
    begin
      unique case (state_reg)
        PDOS_IDLE:
        begin
          // top slot reloaded every idle cycle
          cur_slot_reg <= SLOT_TOP;
          if (shutdown_trigger_in && !load_pending_reg)
            state_reg <= all_zero ? PDOS_DONE : PDOS_STEP;
        end
        PDOS_STEP:
        begin
          // descend from the top
          // a field rewritten mid-run counts only for slots not yet reached
          if (cur_slot_reg == SLOT_BOTTOM)
            state_reg <= PDOS_DONE;
          else if (hit_vec != '0)
          begin
            // pause only after an occupied slot
            state_reg    <= PDOS_GAP;
            gap_cnt_reg  <= GAP_LOAD;
            cur_slot_reg <= cur_slot_reg - 3'h1;
          end
          else
            cur_slot_reg <= cur_slot_reg - 3'h1;
        end
        PDOS_GAP:
        begin
          // GAP_LOAD+1 edges of pause, then back to STEP
          if (gap_cnt_reg == GAP_ZERO)
            state_reg <= PDOS_STEP;
          else
            gap_cnt_reg <= gap_cnt_reg - 9'h001;
        end
        PDOS_DONE:
          // outputs stay off until reset; power-up lives elsewhere
          state_reg <= PDOS_DONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // regulator enables
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      enable_reg <= ALL_ON;
    else if (state_reg == PDOS_IDLE && shutdown_trigger_in && !load_pending_reg && all_zero)
      enable_reg <= ALL_OFF;
    // a field moved above the slot already passed still drops its rail at the bottom slot
    else if (state_reg == PDOS_STEP && cur_slot_reg == SLOT_BOTTOM)
      enable_reg <= ALL_OFF;
    else if (state_reg == PDOS_STEP)
      enable_reg <= enable_reg & ~hit_vec;
  end

  assign output_enable_out = enable_reg;

  ////////////////////////////////////////////////////////////////////////////
  // status flags
  // flags lag the state by one edge so every output is a flop
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      seq_busy_out <= 1'b0;
      seq_done_out <= 1'b0;
    end
    else
    begin
      seq_busy_out <= (state_reg == PDOS_STEP) || (state_reg == PDOS_GAP);
      seq_done_out <= (state_reg == PDOS_DONE);
    end
  end

endmodule : pdos_sequencer

`default_nettype wire

// >>> testbench/pdos_sequencer_assertions.sv
// checker bound to the power-down order sequencer
// assumes it sees only the top module ports
`timescale 1ns/1ps
`default_nettype none
module pdos_sequencer_assertions
  import pdos_pkg::*;
(
  // clock, reset, stimulus
  input wire logic                   sys_clk_in,
  input wire logic                   rst_n_in,
  input wire logic                   shutdown_trigger_in,
  input wire logic                   reg_rd_in,
  input wire logic [ADDR_W-1:0]      reg_addr_in,
  // design outputs
  input wire logic [DATA_W-1:0]      reg_rdata_out,
  input wire logic [NUM_OUTPUTS-1:0] output_enable_out,
  input wire logic                   seq_busy_out,
  input wire logic                   seq_done_out
);
  logic armed_reg;
  logic fired_reg;
  // first edge after release takes no trigger
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      armed_reg <= 1'b0;
    else
      armed_reg <= 1'b1;
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      fired_reg <= 1'b0;
    else if (armed_reg && shutdown_trigger_in)
      fired_reg <= 1'b1;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_idle_take;
    armed_reg && shutdown_trigger_in && !seq_busy_out && !seq_done_out
      && output_enable_out == ALL_ON;
  endsequence
  sequence s_reaction;
    ##[1:3] (seq_busy_out || output_enable_out == ALL_OFF);
  endsequence
  a_rdata_upper_zero: assert property (reg_rdata_out[7:3] == 5'h00)
    else $error("read data upper bits set");
  a_unmapped_read_zero: assert property (reg_rd_in && (reg_addr_in < 8'h5f
    || reg_addr_in > 8'h65) |=> reg_rdata_out == RDATA_RESET)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
    else $error("read data moved without read");
  a_enable_no_rise: assert property ((output_enable_out
    & ~$past(output_enable_out)) == ALL_OFF)
    else $error("an enable came back on");
  a_idle_all_on: assert property (!fired_reg |-> output_enable_out == ALL_ON)
    else $error("output off before trigger");
  a_trigger_starts: assert property (s_idle_take |-> s_reaction)
    else $error("trigger not acted on");
  a_done_holds: assert property (seq_done_out |=> seq_done_out)
    else $error("done dropped");
  a_done_all_off: assert property (seq_done_out |-> output_enable_out == ALL_OFF)
    else $error("done with outputs on");
  a_busy_ends_done: assert property ($fell(seq_busy_out) |-> ##[0:2] seq_done_out)
    else $error("stepping ended without done");
endmodule : pdos_sequencer_assertions
bind pdos_sequencer pdos_sequencer_assertions u_chk (.sys_clk_in, .rst_n_in,
  .shutdown_trigger_in, .reg_rd_in, .reg_addr_in, .reg_rdata_out,
  .output_enable_out, .seq_busy_out, .seq_done_out);
`default_nettype wire

// >>> testbench/test_pdos_sequencer.sv
// self-checking bench for the power-down order sequencer
// assumes package, design and checker compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module test_pdos_sequencer
  import pdos_pkg::*;
;
  logic                          sys_clk_in;
  logic                          rst_n_in;
  logic [NUM_OUTPUTS*SLOT_W-1:0] startup_slot_fused_in;
  logic                          system_on_in;
  logic                          shutdown_trigger_in;
  logic [ADDR_W-1:0]             reg_addr_in;
  logic [DATA_W-1:0]             reg_wdata_in;
  logic                          reg_wr_in;
  logic                          reg_rd_in;
  logic [DATA_W-1:0]             reg_rdata_out;
  logic [NUM_OUTPUTS-1:0]        output_enable_out;
  logic                          seq_busy_out;
  logic                          seq_done_out;
  int                            err_total = 0;
  int                            n_compared = 0;
  int                            cyc = 0;
  int                            sl[NUM_OUTPUTS];
  logic [NUM_OUTPUTS-1:0]        q[$];
  pdos_sequencer i_dut (.sys_clk_in, .rst_n_in, .startup_slot_fused_in, .system_on_in,
    .shutdown_trigger_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .output_enable_out, .seq_busy_out, .seq_done_out);
  initial
  begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  // a hang ends the run as a failure
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      conclude();
    end
  end
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic tick();
    @(posedge sys_clk_in);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic on);
    tick();
    reg_addr_in = a;
    reg_wdata_in = d;
    system_on_in = on;
    reg_wr_in = 1'b1;
    if (on && a >= 8'h5f && a <= 8'h65)
      sl[a - 8'h5f] = d[2:0];
    tick();
    reg_wr_in = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    tick();
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    tick();
    reg_rd_in = 1'b0;
    `CHK(reg_rdata_out, e)
  endtask : rd
  task automatic read_all();
    foreach (sl[i]) rd(BUCK_A_SHUTDOWN_SLOT_ADDR + 8'(i), {5'h00, 3'(sl[i])});
    rd(8'h66, RDATA_RESET);
  endtask : read_all
  // model: one drop mask per occupied slot value, highest first
  task automatic run_seq();
    logic [NUM_OUTPUTS-1:0] prev;
    logic [NUM_OUTPUTS-1:0] m;
    logic [NUM_OUTPUTS-1:0] exp_m;
    logic                   byp;
    int                     gap;
    q = {};
    for (int v = 7; v >= 0; v--)
    begin
      m = ALL_OFF;
      foreach (sl[i]) if (sl[i] == v) m[i] = 1'b1;
      if (m != ALL_OFF) q.push_back(m);
    end
    byp = 1'b1;
    foreach (sl[i]) if (sl[i] != 0) byp = 1'b0;
    prev = ALL_ON;
    gap = SLOT_GAP_CYC;
    tick();
    shutdown_trigger_in = 1'b1;
    while (q.size() > 0)
    begin
      tick();
      // triggers after the first are ignored
      shutdown_trigger_in = 1'($urandom);
      gap++;
      if (output_enable_out !== prev)
      begin
        exp_m = q.pop_front();
        `CHK(prev & ~output_enable_out, exp_m)
        `CHK(seq_busy_out, !byp)
        `CHK(gap >= SLOT_GAP_CYC, 1'b1)
        prev = output_enable_out;
        gap = 0;
      end
    end
    for (int k = 0; k < 300 && seq_done_out !== 1'b1; k++) tick();
    shutdown_trigger_in = 1'b0;
    `CHK(seq_done_out, 1'b1)
    `CHK(seq_busy_out, 1'b0)
    `CHK(output_enable_out, ALL_OFF)
  endtask : run_seq
  initial
  begin
    rst_n_in = 1'b0;
    startup_slot_fused_in = '0;
    system_on_in = 1'b0;
    shutdown_trigger_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    void'($urandom(81));
    // run 0 random writes, run 1 all zero, run 2 fused order
    for (int r = 0; r < 3; r++)
    begin
      rst_n_in = 1'b0;
      startup_slot_fused_in = 21'($urandom);
      foreach (sl[i]) sl[i] = startup_slot_fused_in[3*i +: 3];
      repeat (6) tick();
      rst_n_in = 1'b1;
      tick();
      read_all();
      for (int k = 0; k < 16; k++)
        if (r == 0)
          wr(8'h5e + 8'($urandom % 9), 8'($urandom), 1'($urandom));
        else if (r == 1 && k < 7)
          wr(8'h5f + 8'(k), 8'($urandom) & 8'hf8, 1'b1);
      read_all();
      run_seq();
    end
    conclude();
  end
endmodule : test_pdos_sequencer
`default_nettype wire
